// ===== sfe_map.svh
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define SFE_XW 40
`define SFE_FW 32
`define SFE_EW 8
`define SFE_SHF_W 8

// ----------------------------------------------------------------
// Control operand fields
// ----------------------------------------------------------------
`define SFE_FLD_W 6
`define SFE_POS_LSB 0
`define SFE_LEN_LSB 6
`define SFE_MAX_LEN 7'h20

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define SFE_EXP_ONE 8'h01
`define SFE_RESULT_RST 40'h00_0000_0000

`endif

// ===== sfe_pkg.sv
`default_nettype none
`include "sfe_map.svh"

package sfe_pkg;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    sfe_op_insert  = 3'b000,
    sfe_op_extract = 3'b001,
    sfe_op_norm    = 3'b010,
    sfe_op_lzc     = 3'b011,
    sfe_op_loc     = 3'b100
  } sfe_op_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    sfe_op_t op;
    logic sign_ext;
    logic or_merge;
    logic alu_var;
    logic use_imm;
    logic [`SFE_FLD_W-1:0] imm_pos;
    logic [`SFE_FLD_W-1:0] imm_len;
  } sfe_req_t;

  typedef struct packed {
    logic zero;
    logic overflow;
    logic sign;
  } sfe_flags_t;

endpackage

`default_nettype wire

// ===== sfe_lead_count.sv
`timescale 1ns/1ps
`default_nettype none

module sfe_lead_count #(
  parameter int W = 32,
  parameter int CW = 6
) (
  input wire logic [W-1:0] data_in,
  input wire logic match_in,
  output logic [CW-1:0] count_out
);

  // ----------------------------------------------------------------
  // Run length of match_in from the top bit down
  // ----------------------------------------------------------------
  always_comb begin : run_count
    logic run;
    run = 1'b1;
    count_out = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (run && (data_in[i] == match_in)) begin
        count_out = count_out + 1'b1;
      end else begin
        run = 1'b0;
      end
    end
  end

endmodule // sfe_lead_count

`default_nettype wire

// ===== sfe_unit.sv
// Notes on behaviour
// - Sign-extended insert fills above field with its top bit, unless off-scale.
// - Insert and extract always zero the low extension byte of the result.
// - Position and length accepted 0..63; length effective up to 32 bits.
// - Insert sets overflow when length plus position exceeds 32.
// - OR-merge insert ORs the placed field into the old destination value.
// - Extract takes field from position, right-aligns it, clears bits above.
// - Sign-extended extract fills above field with top bit unless off-scale.
// - Extract sets overflow when length plus position exceeds 32.
// - Field ops set zero flag on zero result; sign flag always cleared.
// - Normalize count writes minus (leading sign bits minus one).
// - Normalize count zero flag on zero exponent; overflow flag cleared.
// - Plain normalize count sign flag equals source bit 31.
// - ALU variant writes +1 when ALU overflow set, else plain exponent.
// - ALU variant sign flag is ALU overflow XOR source bit 31.
// - Leading zero count into position field; zero on top one; overflow at 32.
// - Leading one count written into position field of destination.
// - Leading one count zero on top zero; overflow at 32; sign cleared.
`timescale 1ns/1ps
`default_nettype none
`include "sfe_map.svh"

module sfe_unit (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic op_valid_in,
  input wire sfe_pkg::sfe_req_t req_in,
  input wire logic [`SFE_FW-1:0] src_in,
  input wire logic [`SFE_FW-1:0] ctl_in,
  input wire logic [`SFE_XW-1:0] dst_old_in,
  input wire logic alu_overflow_in,
  output logic [`SFE_XW-1:0] result_out,
  output logic result_valid_out,
  output sfe_pkg::sfe_flags_t flags_out
);

  localparam int FW = `SFE_FW;
  localparam int DW = 2 * `SFE_FW;

  // ----------------------------------------------------------------
  // Operand fields
  // ----------------------------------------------------------------
  logic [`SFE_FLD_W-1:0] fld_pos;
  logic [`SFE_FLD_W-1:0] fld_len;
  logic [`SFE_FLD_W-1:0] len_eff;
  logic [`SFE_FLD_W:0] fld_sum;
  logic fld_off_left;
  logic top_in_range;
  logic [DW-1:0] fld_mask;

  always_comb begin
    fld_pos = req_in.use_imm ? req_in.imm_pos : ctl_in[`SFE_POS_LSB +: `SFE_FLD_W];
    fld_len = req_in.use_imm ? req_in.imm_len : ctl_in[`SFE_LEN_LSB +: `SFE_FLD_W];
    // Lengths past a full word carry no more source bits
    len_eff = ({1'b0, fld_len} > `SFE_MAX_LEN) ? `SFE_FLD_W'(`SFE_MAX_LEN) : fld_len;
    fld_sum = {1'b0, fld_pos} + {1'b0, fld_len};
    fld_off_left = fld_sum > `SFE_MAX_LEN;
    top_in_range = (len_eff != '0) && !fld_off_left;
    fld_mask = (DW'(1) << len_eff) - DW'(1);
  end

  // ----------------------------------------------------------------
  // Field insert
  // ----------------------------------------------------------------
  logic [DW-1:0] ins_placed;
  logic [DW-1:0] ins_ext;
  logic ins_msb;
  logic [FW-1:0] ins_fix;

  always_comb begin
    // Wide shift so positions past the word simply fall off
    ins_placed = ({{FW{1'b0}}, src_in} & fld_mask) << fld_pos;
    ins_ext = ~((DW'(1) << fld_sum) - DW'(1));
    ins_msb = src_in[5'(len_eff - 6'h01)];
    ins_fix = ins_placed[FW-1:0];
    if (req_in.sign_ext && top_in_range && ins_msb) begin
      ins_fix = ins_fix | ins_ext[FW-1:0];
    end
    if (req_in.or_merge) begin
      ins_fix = ins_fix | dst_old_in[`SFE_XW-1:`SFE_EW];
    end
  end

  // ----------------------------------------------------------------
  // Field extract
  // ----------------------------------------------------------------
  logic [DW-1:0] ext_field;
  logic ext_msb;
  logic [FW-1:0] ext_fix;

  always_comb begin
    // Zeros shift in from the left, so off-scale bits read as zero
    ext_field = ({{FW{1'b0}}, src_in} >> fld_pos) & fld_mask;
    ext_msb = src_in[5'(fld_sum - 7'h01)];
    ext_fix = ext_field[FW-1:0];
    if (req_in.sign_ext && top_in_range && ext_msb) begin
      ext_fix = ext_fix | ~fld_mask[FW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Leading bit counts
  // ----------------------------------------------------------------
  logic [`SFE_FLD_W-1:0] lead_zeros;
  logic [`SFE_FLD_W-1:0] lead_ones;
  logic [`SFE_FLD_W-1:0] lead_sign;
  logic [`SFE_SHF_W-1:0] norm_exp;

  sfe_lead_count #(
    .W(FW),
    .CW(`SFE_FLD_W)
  ) u_lead_zeros (
    .data_in(src_in),
    .match_in(1'b0),
    .count_out(lead_zeros)
  );

  sfe_lead_count #(
    .W(FW),
    .CW(`SFE_FLD_W)
  ) u_lead_ones (
    .data_in(src_in),
    .match_in(1'b1),
    .count_out(lead_ones)
  );

  always_comb begin
    lead_sign = src_in[FW-1] ? lead_ones : lead_zeros;
    // Negating (count - 1) is the same as 1 - count
    norm_exp = `SFE_EXP_ONE - {2'b00, lead_sign};
    if (req_in.alu_var && alu_overflow_in) begin
      // The ALU overflow bit is one extra bit of magnitude
      norm_exp = `SFE_EXP_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Result and flag selection
  // ----------------------------------------------------------------
  logic [`SFE_XW-1:0] result_d;
  logic [`SFE_XW-1:0] result_q;
  logic valid_d;
  logic valid_q;
  sfe_pkg::sfe_flags_t flags_d;
  sfe_pkg::sfe_flags_t flags_q;
  logic [FW-1:0] fix_d;

  always_comb begin
    result_d = result_q;
    flags_d = flags_q;
    valid_d = 1'b0;
    fix_d = '0;
    if (op_valid_in) begin
      valid_d = 1'b1;
      case (req_in.op)
        sfe_pkg::sfe_op_insert: begin
          fix_d = ins_fix;
          flags_d.zero = (ins_fix == '0);
          flags_d.overflow = fld_off_left;
          flags_d.sign = 1'b0;
        end
        sfe_pkg::sfe_op_extract: begin
          fix_d = ext_fix;
          flags_d.zero = (ext_fix == '0);
          flags_d.overflow = fld_off_left;
          flags_d.sign = 1'b0;
        end
        sfe_pkg::sfe_op_norm: begin
          fix_d = {{(FW - `SFE_SHF_W){1'b0}}, norm_exp};
          flags_d.zero = (norm_exp == '0);
          flags_d.overflow = 1'b0;
          if (req_in.alu_var) begin
            flags_d.sign = alu_overflow_in ^ src_in[FW-1];
          end else begin
            flags_d.sign = src_in[FW-1];
          end
        end
        sfe_pkg::sfe_op_lzc: begin
          fix_d = {{(FW - `SFE_FLD_W){1'b0}}, lead_zeros};
          flags_d.zero = src_in[FW-1];
          flags_d.overflow = ({1'b0, lead_zeros} == `SFE_MAX_LEN);
          flags_d.sign = 1'b0;
        end
        sfe_pkg::sfe_op_loc: begin
          fix_d = {{(FW - `SFE_FLD_W){1'b0}}, lead_ones};
          flags_d.zero = !src_in[FW-1];
          flags_d.overflow = ({1'b0, lead_ones} == `SFE_MAX_LEN);
          flags_d.sign = 1'b0;
        end
        default: begin
          // Unknown codes leave result and flags untouched
          valid_d = 1'b0;
          fix_d = result_q[`SFE_XW-1:`SFE_EW];
        end
      endcase
      result_d = {fix_d, {`SFE_EW{1'b0}}};
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      result_q <= `SFE_RESULT_RST;
      valid_q <= 1'b0;
      flags_q <= '0;
    end else begin
      result_q <= result_d;
      valid_q <= valid_d;
      flags_q <= flags_d;
    end
  end

  assign result_out = result_q;
  assign result_valid_out = valid_q;
  assign flags_out = flags_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_clk @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  logic is_field_op;
  assign is_field_op = op_valid_in &&
    ((req_in.op == sfe_pkg::sfe_op_insert) || (req_in.op == sfe_pkg::sfe_op_extract));

  chk_ext_byte_zero: assert property (
    is_field_op |=> (result_out[`SFE_EW-1:0] == 8'h00) && result_valid_out)
    else $error("Extension byte not cleared on field operation");

  chk_insert_ovf_flag: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_insert)
    |=> flags_out.overflow == ($past(fld_sum) > 7'h20))
    else $error("Insert overflow flag wrong");

  chk_extract_ovf_flag: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_extract)
    |=> flags_out.overflow == ($past(fld_sum) > 7'h20))
    else $error("Extract overflow flag wrong");

  chk_field_zero_sign: assert property (
    is_field_op |=> !flags_out.sign && (flags_out.zero == (result_out == 40'h00_0000_0000)))
    else $error("Field operation zero or sign flag wrong");

  chk_extract_upper_clear: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_extract) && !req_in.sign_ext
    && (len_eff < 6'h20)
    |=> (result_out[`SFE_XW-1:`SFE_EW] >> $past(len_eff)) == 32'h0000_0000)
    else $error("Extract left bits above field");

  chk_norm_flags: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_norm)
    |=> !flags_out.overflow && (flags_out.zero == (result_out[15:8] == 8'h00))
    && (result_out[39:16] == 24'h00_0000))
    else $error("Normalize count flags or layout wrong");

  chk_norm_plain_sign: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_norm) && !req_in.alu_var
    |=> flags_out.sign == $past(src_in[31]))
    else $error("Normalize count sign flag wrong");

  chk_alu_var_one: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_norm) && req_in.alu_var && alu_overflow_in
    |=> result_out[15:8] == 8'h01)
    else $error("ALU variant did not give plus one");

  chk_alu_var_sign: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_norm) && req_in.alu_var
    |=> flags_out.sign == ($past(alu_overflow_in) ^ $past(src_in[31])))
    else $error("ALU variant sign flag wrong");

  chk_lzc_flags: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_lzc)
    |=> (flags_out.zero == $past(src_in[31]))
    && (flags_out.overflow == (result_out[13:8] == 6'h20)))
    else $error("Leading zero count flags wrong");

  chk_loc_flags: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_loc)
    |=> (flags_out.zero == !$past(src_in[31])) && !flags_out.sign
    && (flags_out.overflow == (result_out[13:8] == 6'h20)))
    else $error("Leading one count flags wrong");

  chk_insert_sign_fill: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_insert) && req_in.sign_ext
    && top_in_range && ins_msb |=> result_out[`SFE_XW-1])
    else $error("Insert sign extension missing");

  chk_merge_keeps_old: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_insert) && req_in.or_merge
    |=> (result_out[`SFE_XW-1:`SFE_EW] & $past(dst_old_in[`SFE_XW-1:`SFE_EW]))
    == $past(dst_old_in[`SFE_XW-1:`SFE_EW]))
    else $error("OR-merge lost old destination bits");

  chk_extract_sign_fill: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_extract) && req_in.sign_ext
    && top_in_range && ext_msb |=> result_out[`SFE_XW-1])
    else $error("Extract sign extension missing");

  chk_loc_layout: assert property (
    op_valid_in && (req_in.op == sfe_pkg::sfe_op_loc)
    |=> result_out[`SFE_XW-1:14] == 26'h0000000)
    else $error("Leading one count outside its field");

  chk_undef_ignored: assert property (
    op_valid_in && (req_in.op > sfe_pkg::sfe_op_loc)
    |=> !result_valid_out && $stable(result_out) && $stable(flags_out))
    else $error("Undefined operation changed outputs");

  chk_idle_hold: assert property (
    !op_valid_in |=> !result_valid_out && $stable(result_out) && $stable(flags_out))
    else $error("Outputs moved without a request");

endmodule // sfe_unit

`default_nettype wire

// ===== sfe_rf_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Destination register of the core register file
// ----------------------------------------------------------------
module sfe_rf_model (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic result_valid_in,
  input wire logic [39:0] result_in,
  output logic [39:0] dst_out
);
  logic [39:0] word_q;
  logic [39:0] word_d;

  always_comb begin
    word_d = result_valid_in ? result_in : word_q;
  end

  always_ff @(posedge clk_in) begin
    word_q <= srst_in ? 40'h00_0000_0000 : word_d;
  end

  // Write-through bypass, so back-to-back merges see the fresh value
  assign dst_out = word_d;
endmodule // sfe_rf_model

`default_nettype wire

// ===== sfe_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none

`define SFE_CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %0t %s", $time, msg); end end

module sfe_unit_bench;
  typedef struct {logic [39:0] res; logic [39:0] msk; sfe_pkg::sfe_flags_t fl;} sfe_exp_t;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic op_valid_in = 1'b0;
  sfe_pkg::sfe_req_t req_in = '0;
  logic [31:0] src_in = 32'h0;
  logic [31:0] ctl_in = 32'h0;
  logic [39:0] dst_old_in;
  logic alu_overflow_in = 1'b0;
  logic [39:0] result_out;
  logic result_valid_out;
  sfe_pkg::sfe_flags_t flags_out;
  int fails = 0;
  int cmp_count = 0;
  integer seed = 32'h1049;
  sfe_exp_t q[$];

  sfe_unit u_sfe_unit (.clk_in(clk_in), .srst_in(srst_in), .op_valid_in(op_valid_in),
    .req_in(req_in), .src_in(src_in), .ctl_in(ctl_in), .dst_old_in(dst_old_in),
    .alu_overflow_in(alu_overflow_in), .result_out(result_out),
    .result_valid_out(result_valid_out), .flags_out(flags_out));
  sfe_rf_model u_sfe_rf_model (.clk_in(clk_in), .srst_in(srst_in),
    .result_valid_in(result_valid_out), .result_in(result_out), .dst_out(dst_old_in));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Reference behaviour
  // ----------------------------------------------------------------
  function automatic sfe_exp_t model(sfe_pkg::sfe_req_t r, logic [31:0] s, logic [31:0] c,
                                     logic [39:0] d, logic av);
    sfe_exp_t e;
    int p, l, le, n;
    logic [63:0] m, f;
    logic [7:0] x;
    logic b;
    p = r.use_imm ? r.imm_pos : c[5:0];
    l = r.use_imm ? r.imm_len : c[11:6];
    le = (l > 32) ? 32 : l;
    m = (64'h1 << le) - 64'h1;
    e.fl = '0;
    e.msk = 40'hFF_FFFF_FFFF;
    if (r.op == sfe_pkg::sfe_op_insert) begin
      f = ({32'h0, s} & m) << p;
      if (r.sign_ext && le > 0 && p + l <= 32 && s[le-1]) f |= ~64'h0 << (p + l);
      if (r.or_merge) f[31:0] |= d[39:8];
    end else begin
      f = ({32'h0, s} >> p) & m;
      if (r.sign_ext && le > 0 && p + l <= 32 && s[p+l-1]) f |= ~64'h0 << le;
    end
    e.res = {f[31:0], 8'h00};
    e.fl.zero = (f[31:0] == 32'h0);
    e.fl.overflow = (p + l > 32);
    if (r.op > sfe_pkg::sfe_op_extract) begin
      b = (r.op == sfe_pkg::sfe_op_lzc) ? 1'b0 : (r.op == sfe_pkg::sfe_op_loc) ? 1'b1 : s[31];
      n = 0;
      while (n < 32 && s[31-n] == b) n++;
      e.fl.overflow = (r.op != sfe_pkg::sfe_op_norm) && (n == 32);
      e.msk = 40'h00_0000_3FFF;
      e.res = {26'h0, n[5:0], 8'h00};
      e.fl.zero = s[31] ^ (r.op == sfe_pkg::sfe_op_loc);
      if (r.op == sfe_pkg::sfe_op_norm) begin
        x = 8'h01 - n[7:0];
        if (r.alu_var && av) x = 8'h01;
        e.msk = 40'h00_0000_FFFF;
        e.res = {24'h0, x, 8'h00};
        e.fl.zero = (x == 8'h00);
        e.fl.sign = s[31] ^ (r.alu_var & av);
      end
    end
    return e;
  endfunction

  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    #1;
    `SFE_CHK(result_valid_out, q.size() != 0, "valid pulse")
    if (result_valid_out === 1'b1 && q.size() != 0) begin
      `SFE_CHK(result_out & q[0].msk, q[0].res & q[0].msk, "result")
      `SFE_CHK(flags_out, q[0].fl, "flags")
      void'(q.pop_front());
    end
  end

  initial begin
    #100000;
    fails++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v, w;
    logic [39:0] dexp;
    logic prev_field;
    sfe_exp_t e;
    sfe_pkg::sfe_req_t r;
    dexp = 40'h0;
    prev_field = 1'b1;
    repeat (20) @(negedge clk_in);
    srst_in = 1'b0;
    `SFE_CHK({result_out, result_valid_out, flags_out}, 44'h0, "reset state")
    for (int i = 0; i < 800; i++) begin
      @(negedge clk_in);
      v = $random(seed);
      w = $random(seed);
      r = sfe_pkg::sfe_req_t'($random(seed));
      r.op = sfe_pkg::sfe_op_t'(v[2:0]);
      if (!prev_field) r.or_merge = 1'b0;
      if (v[16]) r.imm_pos = 6'(32 - r.imm_len[4:0] + v[17]);
      req_in = r;
      // Self-determined shift, else the unsigned arm turns it logical
      src_in = (v[12:11] == 2'b00) ? {32{v[13]}} : $unsigned($signed(w) >>> v[10:6]);
      ctl_in = $random(seed);
      alu_overflow_in = v[18];
      op_valid_in = ~v[14] | v[15];
      if (op_valid_in && v[2:0] <= 3'h4) begin
        e = model(req_in, src_in, ctl_in, dexp, alu_overflow_in);
        q.push_back(e);
        dexp = e.res;
        prev_field = (v[2:0] <= 3'h1);
      end
    end
    @(negedge clk_in);
    op_valid_in = 1'b0;
    for (int t = 0; t < 20 && q.size() > 0; t++) @(negedge clk_in);
    if (q.size() > 0) begin
      fails++;
      $display("[FAIL] %0t missing results", $time);
    end
    report_and_stop();
  end
endmodule // sfe_unit_bench

`default_nettype wire
